// >>> include/ssc_defs.svh
// Constants of the step sequencer core: register map, fields, resets, timing.
// Assumes a 100 MHz hclk; included by bare name.
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH

`define SSC_CLK_MHZ 100

// ****************
// Register offsets
// ****************
`define SSC_A_CTRL 8'h00
`define SSC_A_TEMPO 8'h04
`define SSC_A_TRANSP 8'h08
`define SSC_A_STATUS 8'h0C
`define SSC_A_SLOT 8'h10

// ****************
// Fields and resets
// ****************
`define SSC_CTRL_MODE_LSB 0
`define SSC_CTRL_QUANT 2
`define SSC_CTRL_WIPE 3
`define SSC_TEMPO_RST 32'h00B71B00
`define SSC_LEN_RST 7'h10
`define SSC_LEN_MAX 7'h40
`define SSC_GATE_BLANK 7'h50
`define SSC_SLOTS 99
`define SSC_AUX_MV_PER 80
`define SSC_IVL_BIAS 24
`define SSC_NOTE_BASE 12

// ****************
// Timing
// ****************
`define SSC_BLINK_MS 400
`define SSC_BLINK_CYC (`SSC_BLINK_MS * `SSC_CLK_MHZ * 1000)
`define SSC_BLIP_MS 60
`define SSC_BLIP_CYC (`SSC_BLIP_MS * `SSC_CLK_MHZ * 1000)
`define SSC_DBL_MS 400
`define SSC_DBL_CYC (`SSC_DBL_MS * `SSC_CLK_MHZ * 1000)
`define SSC_DUP_MS 500
`define SSC_DUP_CYC (`SSC_DUP_MS * `SSC_CLK_MHZ * 1000)

`endif

// >>> include/ssc_pkg.sv
// Types shared by the step sequencer core.
// Assumes nothing beyond a SystemVerilog compiler.
package ssc_pkg;

  typedef enum logic [1:0] {
    aux_stepped = 2'b00,
    smoothed_mode = 2'b01,
    aux_interval = 2'b10,
    aux_note = 2'b11
  } ssc_aux_mode_e;

  typedef enum logic [2:0] {
    walk_idle = 3'b000,
    walk_store = 3'b001,
    walk_load = 3'b010,
    walk_blank = 3'b011,
    walk_bar = 3'b100
  } ssc_walk_e;

  typedef enum logic [1:0] {
    arm_none = 2'b00,
    arm_store = 2'b01,
    arm_recall = 2'b10
  } ssc_arm_e;

  typedef struct packed {
    logic active;
    logic [3:0] note;
    logic [2:0] oct;
    logic [6:0] gate;
    logic [7:0] aux;
  } ssc_step_s;

endpackage : ssc_pkg

// >>> logic/ssc_core.sv
// Step sequencer core: transport, patch slots, step editing, aux output modes.
// Assumes AHB-Lite master on hclk, asynchronous panel pins and jacks.
// Behaviour
// - Run button alone toggles playback
// - Shift plus run returns to first step
// - External clock pulse stops internal clock, advances
// - Store/recall: arm, pick slot 1-99, confirm
// - Decimal point marks occupied slot while choosing
// - Double press stores last slot, reloads last
// - Recalling empty slot loads blank sequence
// - Loaded sequence keeps current play position
// - Step press selects/activates, again deactivates
// - Selected step LED blinks by active state
// - Only active steps drive gate and outputs
// - Length defaults 16, range 1 to 64
// - Shift held: length jumps through table
// - Shift plus step 1-4 picks bar
// - Steps beyond length are never played
// - Shift, source, destination copies bar, flashes
// - Capture writes first moved knob, active steps
// - Aux mode per sequence, blank resets stepped
// - Stepped mode jumps, 0-100 to 0-8V
// - Smoothed mode ramps over each step
// - Interval mode: pitch plus offset, quantized
// - Note mode: own 1-5V pitch, active only
// - Wipe clears steps, gate length 80
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "ssc_defs.svh"
module ssc_core #(
  parameter int SLOTS = `SSC_SLOTS,
  parameter int BLINK_CYC = `SSC_BLINK_CYC,
  parameter int BLIP_CYC = `SSC_BLIP_CYC,
  parameter int DBL_CYC = `SSC_DBL_CYC,
  parameter int DUP_CYC = `SSC_DUP_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Panel
  input wire logic run_btn,
  input wire logic shift_btn,
  input wire logic store_btn,
  input wire logic recall_btn,
  input wire logic capture_btn,
  input wire logic [15:0] step_btn,
  input wire logic enc_up,
  input wire logic enc_dn,
  input wire logic [3:0] knob_move,
  input wire logic [7:0] knob_val,
  // Jacks
  input wire logic ext_clk,
  input wire logic ext_rst,
  // Outputs
  output logic gate_out,
  output logic [13:0] pitch_mv,
  output logic [13:0] aux_voltage_output,
  output logic [15:0] step_led,
  output logic [6:0] slot_num,
  output logic slot_dp,
  output logic duplicate_indicator
);
  if (SLOTS < 1 || SLOTS > 99 || BLIP_CYC >= BLINK_CYC) begin : g_chk
    $error("ssc_core: unsupported parameter values");
  end

  localparam logic [6:0] LEN_TAB [8] = '{7'h04, 7'h08, 7'h0C, 7'h10, 7'h18, 7'h20, 7'h30, 7'h40};
  localparam ssc_pkg::ssc_step_s BLANK = '{1'b0, 4'h0, 3'h0, `SSC_GATE_BLANK, 8'h00};

  // ****************
  // Input synchronisers
  // ****************
  logic [36:0] s, sp, rise;
  ssc_sync #(.WIDTH(37)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .din({knob_val, knob_move, enc_dn, enc_up, step_btn, capture_btn, recall_btn, store_btn,
          shift_btn, run_btn, ext_rst, ext_clk}),
    .dout(s)
  );
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sp <= '0;
    else sp <= s;
  end
  assign rise = s & ~sp;

  logic shift_h, cap_h;
  logic [15:0] step_h, step_r;
  logic [3:0] knob_r;
  logic [7:0] kval;
  assign shift_h = s[3];
  assign cap_h = s[6];
  assign step_h = s[22:7];
  assign step_r = rise[22:7];
  assign knob_r = rise[28:25];
  assign kval = s[36:29];

  function automatic logic [3:0] low_bit(input logic [15:0] v);
    low_bit = 4'h0;
    for (int i = 15; i >= 0; i--) if (v[i]) low_bit = 4'(i);
  endfunction : low_bit

  function automatic logic [13:0] semi_mv(input int v_in, input logic q);
    int v;
    v = (v_in < 0) ? 0 : v_in;
    // Snap accidentals down onto the major scale
    if (q && ((v % 12) inside {1, 3, 6, 8, 10})) v = v - 1;
    semi_mv = 14'((v * 1000) / 12);
  endfunction : semi_mv

  function automatic ssc_pkg::ssc_step_s upd(input ssc_pkg::ssc_step_s st, input logic [1:0] k,
                                             input logic [7:0] val);
    upd = st;
    unique case (k)
      2'd0: upd.note = (val[3:0] > 4'hB) ? 4'hB : val[3:0];
      2'd1: upd.oct = val[2:0];
      2'd2: upd.gate = val[6:0];
      2'd3: upd.aux = val;
    endcase
  endfunction : upd

  // ****************
  // Registers and state
  // ****************
  ssc_pkg::ssc_step_s seq_mem [64];
  ssc_pkg::ssc_step_s slot_mem [SLOTS*64];
  ssc_pkg::ssc_aux_mode_e slot_mode [SLOTS];
  logic [SLOTS-1:0] slot_used_reg;
  ssc_pkg::ssc_walk_e walk_reg;
  ssc_pkg::ssc_arm_e arm_reg;
  ssc_pkg::ssc_aux_mode_e aux_mode_reg;
  logic [5:0] walk_cnt_reg, pos_reg, sel_reg;
  logic [6:0] walk_slot_reg, slot_sel_reg, last_slot_reg, last_store_reg, len_reg;
  logic [6:0] transp_reg;
  logic [1:0] view_bar_reg, src_reg, dst_reg, cap_knob_reg;
  logic [31:0] tempo_reg, tick_reg, period_reg, gap_reg, dbl_reg, dup_reg, blink_reg, gate_cnt_reg;
  logic [31:0] acc_reg;
  logic [13:0] aux_tgt_reg, delta_reg;
  logic quant_reg, running_reg, ext_mode_reg, restart_reg, play_reg, len_edit_reg;
  logic srcv_reg, selv_reg, cap_valid_reg;

  // ****************
  // AHB-Lite slave, zero wait states
  // ****************
  logic take, ap_wr_reg;
  logic [7:0] ap_addr_reg;
  logic [31:0] rd_mux;
  logic wr_ctrl, wipe_req;
  assign take = hsel && hready && htrans[1] && hsize == 3'b010;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_ctrl = ap_wr_reg && ap_addr_reg == `SSC_A_CTRL;
  assign wipe_req = wr_ctrl && hwdata[`SSC_CTRL_WIPE];

  always_comb begin
    rd_mux = 32'h0;
    unique case (haddr[7:0])
      `SSC_A_CTRL: rd_mux = {29'h0, quant_reg, aux_mode_reg};
      `SSC_A_TEMPO: rd_mux = tempo_reg;
      `SSC_A_TRANSP: rd_mux = {{25{transp_reg[6]}}, transp_reg};
      `SSC_A_STATUS: rd_mux = {5'h00, running_reg, ext_mode_reg, walk_reg != ssc_pkg::walk_idle, arm_reg,
                               view_bar_reg, len_reg, pos_reg, selv_reg, sel_reg};
      `SSC_A_SLOT: rd_mux = {23'h0, slot_dp, 1'b0, slot_sel_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      ap_wr_reg <= take && hwrite;
      ap_addr_reg <= haddr[7:0];
      hrdata <= (take && !hwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tempo_reg <= `SSC_TEMPO_RST;
      transp_reg <= 7'h00;
      quant_reg <= 1'b0;
    end else if (ap_wr_reg) begin
      if (ap_addr_reg == `SSC_A_TEMPO) tempo_reg <= hwdata;
      if (ap_addr_reg == `SSC_A_TRANSP) transp_reg <= hwdata[6:0];
      if (wr_ctrl) quant_reg <= hwdata[`SSC_CTRL_QUANT];
    end
  end

  // ****************
  // Slot selection
  // ****************
  logic idle, commit_store, commit_recall, start_load, start_blank, start_bar;
  logic [6:0] commit_slot;
  logic [3:0] sb;
  assign idle = walk_reg == ssc_pkg::walk_idle;
  assign commit_store = arm_reg == ssc_pkg::arm_store && rise[4] && idle;
  assign commit_recall = arm_reg == ssc_pkg::arm_recall && rise[5] && idle;
  // Second press inside the window ignores the encoder choice and reuses the remembered slot
  assign commit_slot = (dbl_reg == 32'h0) ? slot_sel_reg :
                       (commit_store ? last_slot_reg : last_store_reg);
  assign start_load = commit_recall && slot_used_reg[commit_slot - 7'h01];
  assign start_blank = (commit_recall && !slot_used_reg[commit_slot - 7'h01]) || (wipe_req && idle);
  assign slot_dp = arm_reg != ssc_pkg::arm_none && slot_used_reg[slot_sel_reg - 7'h01];
  assign slot_num = (arm_reg != ssc_pkg::arm_none) ? slot_sel_reg : 7'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_reg <= ssc_pkg::arm_none;
      slot_sel_reg <= 7'h01;
      last_slot_reg <= 7'h01;
      last_store_reg <= 7'h01;
      dbl_reg <= 32'h0;
    end else begin
      dbl_reg <= (dbl_reg != 32'h0) ? dbl_reg - 32'h1 : 32'h0;
      if (arm_reg == ssc_pkg::arm_none) begin
        if (rise[4]) begin
          arm_reg <= ssc_pkg::arm_store;
          slot_sel_reg <= last_slot_reg;
          dbl_reg <= 32'(DBL_CYC);
        end else if (rise[5]) begin
          arm_reg <= ssc_pkg::arm_recall;
          slot_sel_reg <= last_store_reg;
          dbl_reg <= 32'(DBL_CYC);
        end
      end else if (rise[3]) begin
        arm_reg <= ssc_pkg::arm_none;
      end else if (commit_store || commit_recall) begin
        arm_reg <= ssc_pkg::arm_none;
        last_slot_reg <= commit_slot;
        if (commit_store) last_store_reg <= commit_slot;
      end else if (rise[23] && slot_sel_reg < 7'(SLOTS)) begin
        slot_sel_reg <= slot_sel_reg + 7'h01;
      end else if (rise[24] && slot_sel_reg > 7'h01) begin
        slot_sel_reg <= slot_sel_reg - 7'h01;
      end
    end
  end

  // ****************
  // Sequence length
  // ****************
  function automatic logic [6:0] next_len(input logic [6:0] cur, input logic up, input logic coarse);
    next_len = cur;
    if (!coarse) begin
      if (up && cur < `SSC_LEN_MAX) next_len = cur + 7'h01;
      if (!up && cur > 7'h01) next_len = cur - 7'h01;
    end else if (up) begin
      for (int i = 7; i >= 0; i--) if (LEN_TAB[i] > cur) next_len = LEN_TAB[i];
    end else begin
      for (int i = 0; i < 8; i++) if (LEN_TAB[i] < cur) next_len = LEN_TAB[i];
    end
  endfunction : next_len

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      len_reg <= `SSC_LEN_RST;
      len_edit_reg <= 1'b0;
    end else begin
      if (|step_r) len_edit_reg <= shift_h && low_bit(step_r) == 4'h9;
      if (len_edit_reg && arm_reg == ssc_pkg::arm_none && (rise[23] ^ rise[24]))
        len_reg <= next_len(len_reg, rise[23], shift_h);
    end
  end

  // ****************
  // Bar view, copy and step selection
  // ****************
  assign sb = low_bit(step_r);
  assign start_bar = |step_r && shift_h && sb < 4'h4 && srcv_reg && step_h[src_reg] && sb[1:0] != src_reg && idle;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      view_bar_reg <= 2'h0;
      src_reg <= 2'h0;
      srcv_reg <= 1'b0;
      sel_reg <= 6'h00;
      selv_reg <= 1'b0;
      dup_reg <= 32'h0;
    end else begin
      dup_reg <= start_bar ? 32'(DUP_CYC) : ((dup_reg != 32'h0) ? dup_reg - 32'h1 : 32'h0);
      if (!shift_h) srcv_reg <= 1'b0;
      if (|step_r && shift_h && sb < 4'h4 && !start_bar) begin
        view_bar_reg <= sb[1:0];
        src_reg <= sb[1:0];
        srcv_reg <= 1'b1;
      end else if (|step_r && !shift_h && idle) begin
        sel_reg <= {view_bar_reg, sb};
        selv_reg <= 1'b1;
      end
    end
  end
  assign duplicate_indicator = dup_reg != 32'h0;

  // ****************
  // Transport
  // ****************
  logic adv;
  assign adv = rise[0] || (running_reg && tick_reg == 32'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      running_reg <= 1'b0;
      ext_mode_reg <= 1'b0;
      restart_reg <= 1'b1;
      pos_reg <= 6'h00;
      tick_reg <= 32'h0;
      gap_reg <= 32'h0;
      period_reg <= `SSC_TEMPO_RST;
      play_reg <= 1'b0;
    end else begin
      play_reg <= adv;
      gap_reg <= rise[0] ? 32'h0 : gap_reg + 32'h1;
      tick_reg <= (tick_reg == 32'h0 || !running_reg) ? tempo_reg - 32'h1 : tick_reg - 32'h1;
      if (rise[0]) begin
        running_reg <= 1'b0;
        ext_mode_reg <= 1'b1;
        period_reg <= gap_reg;
      end else if (rise[2] && !shift_h) begin
        running_reg <= !running_reg;
        ext_mode_reg <= 1'b0;
        period_reg <= tempo_reg;
      end
      if ((rise[2] && shift_h) || rise[1]) begin
        pos_reg <= 6'h00;
        restart_reg <= 1'b1;
      end else if (adv) begin
        restart_reg <= 1'b0;
        // Wrap at the programmed length so later bars stay silent
        if (restart_reg) pos_reg <= 6'h00;
        else pos_reg <= (7'(pos_reg) + 7'h01 >= len_reg) ? 6'h00 : pos_reg + 6'h01;
      end
    end
  end

  // ****************
  // Copy engine and step memory
  // ****************
  logic [5:0] wr_idx;
  logic wr_en, cap_wr, knob_wr;
  ssc_pkg::ssc_step_s wr_data, cur;
  logic [12:0] slot_addr;
  assign cur = seq_mem[pos_reg];
  assign slot_addr = {walk_slot_reg - 7'h01, walk_cnt_reg};
  assign cap_wr = cap_valid_reg && play_reg && cur.active && (running_reg || ext_mode_reg) && idle;
  assign knob_wr = |knob_r && !cap_h && selv_reg && idle;

  always_comb begin
    wr_en = 1'b1;
    wr_idx = walk_cnt_reg;
    wr_data = BLANK;
    if (walk_reg == ssc_pkg::walk_load) begin
      wr_data = slot_mem[slot_addr];
    end else if (walk_reg == ssc_pkg::walk_blank) begin
      wr_data = BLANK;
    end else if (walk_reg == ssc_pkg::walk_bar) begin
      wr_idx = {dst_reg, walk_cnt_reg[3:0]};
      wr_data = seq_mem[{src_reg, walk_cnt_reg[3:0]}];
    end else if (cap_wr) begin
      wr_idx = pos_reg;
      wr_data = upd(cur, cap_knob_reg, kval);
    end else if (knob_wr) begin
      wr_idx = sel_reg;
      wr_data = upd(seq_mem[sel_reg], 2'(low_bit({12'h000, knob_r})), kval);
    end else if (|step_r && !shift_h && idle) begin
      wr_idx = {view_bar_reg, sb};
      wr_data = seq_mem[wr_idx];
      wr_data.active = !(selv_reg && sel_reg == wr_idx);
    end else begin
      wr_en = 1'b0;
    end
  end

  always_ff @(posedge hclk) begin
    if (wr_en) seq_mem[wr_idx] <= wr_data;
    if (walk_reg == ssc_pkg::walk_store) slot_mem[slot_addr] <= seq_mem[walk_cnt_reg];
  end

  always_ff @(posedge hclk) begin
    if (commit_store) slot_mode[commit_slot - 7'h01] <= aux_mode_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      walk_reg <= ssc_pkg::walk_blank;
      walk_cnt_reg <= 6'h00;
      walk_slot_reg <= 7'h01;
      dst_reg <= 2'h0;
      slot_used_reg <= '0;
    end else begin
      // Position is left alone so a recalled sequence picks up in place
      unique case (walk_reg)
        ssc_pkg::walk_idle: begin
          walk_cnt_reg <= 6'h00;
          walk_slot_reg <= commit_slot;
          dst_reg <= sb[1:0];
          if (commit_store) walk_reg <= ssc_pkg::walk_store;
          else if (start_load) walk_reg <= ssc_pkg::walk_load;
          else if (start_blank) walk_reg <= ssc_pkg::walk_blank;
          else if (start_bar) walk_reg <= ssc_pkg::walk_bar;
        end
        ssc_pkg::walk_bar: begin
          walk_cnt_reg <= walk_cnt_reg + 6'h01;
          if (walk_cnt_reg == 6'h0F) walk_reg <= ssc_pkg::walk_idle;
        end
        default: begin
          walk_cnt_reg <= walk_cnt_reg + 6'h01;
          if (walk_cnt_reg == 6'h3F) begin
            walk_reg <= ssc_pkg::walk_idle;
            if (walk_reg == ssc_pkg::walk_store) slot_used_reg[walk_slot_reg - 7'h01] <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) aux_mode_reg <= ssc_pkg::aux_stepped;
    else if (start_load) aux_mode_reg <= slot_mode[commit_slot - 7'h01];
    else if (start_blank) aux_mode_reg <= ssc_pkg::aux_stepped;
    else if (wr_ctrl) aux_mode_reg <= ssc_pkg::ssc_aux_mode_e'(hwdata[`SSC_CTRL_MODE_LSB +: 2]);
  end

  // ****************
  // Capture
  // ****************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_valid_reg <= 1'b0;
      cap_knob_reg <= 2'h0;
    end else if (!cap_h) begin
      cap_valid_reg <= 1'b0;
    end else if (!cap_valid_reg && |knob_r) begin
      cap_valid_reg <= 1'b1;
      cap_knob_reg <= 2'(low_bit({12'h000, knob_r}));
    end
  end

  // ****************
  // Gate, pitch and aux outputs
  // ****************
  int semi;
  logic [13:0] aux_new;
  assign semi = int'(cur.oct) * 12 + int'(cur.note) + int'($signed(transp_reg));

  always_comb begin
    unique case (aux_mode_reg)
      ssc_pkg::aux_interval: aux_new = semi_mv(semi + int'(cur.aux) - `SSC_IVL_BIAS, quant_reg);
      ssc_pkg::aux_note: aux_new = semi_mv(`SSC_NOTE_BASE + int'(cur.aux) + int'($signed(transp_reg)),
                                            quant_reg);
      default: aux_new = 14'(int'(cur.aux) * `SSC_AUX_MV_PER);
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_cnt_reg <= 32'h0;
      gate_out <= 1'b0;
      pitch_mv <= 14'h0000;
    end else begin
      gate_out <= gate_cnt_reg != 32'h0;
      if (play_reg && cur.active) begin
        gate_cnt_reg <= 32'((period_reg >> 7) * 32'(cur.gate));
        pitch_mv <= semi_mv(semi, quant_reg);
      end else if (gate_cnt_reg != 32'h0) begin
        gate_cnt_reg <= gate_cnt_reg - 32'h1;
      end
    end
  end

  // Ramp moves one millivolt per carry; a step shorter than its swing ends early
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_voltage_output <= 14'h0000;
      aux_tgt_reg <= 14'h0000;
      delta_reg <= 14'h0000;
      acc_reg <= 32'h0;
    end else if (play_reg && cur.active) begin
      aux_tgt_reg <= aux_new;
      acc_reg <= 32'h0;
      delta_reg <= (aux_new > aux_voltage_output) ? aux_new - aux_voltage_output : aux_voltage_output - aux_new;
      if (aux_mode_reg != ssc_pkg::smoothed_mode) aux_voltage_output <= aux_new;
    end else if (aux_mode_reg == ssc_pkg::smoothed_mode && aux_voltage_output != aux_tgt_reg) begin
      if (acc_reg + 32'(delta_reg) >= period_reg) begin
        acc_reg <= acc_reg + 32'(delta_reg) - period_reg;
        aux_voltage_output <= (aux_tgt_reg > aux_voltage_output) ? aux_voltage_output + 14'h0001 :
                                                                  aux_voltage_output - 14'h0001;
      end else begin
        acc_reg <= acc_reg + 32'(delta_reg);
      end
    end
  end

  // ****************
  // Step LEDs
  // ****************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_reg <= 32'h0;
      step_led <= 16'h0000;
    end else begin
      blink_reg <= (blink_reg >= 32'(BLINK_CYC - 1)) ? 32'h0 : blink_reg + 32'h1;
      for (int i = 0; i < 16; i++) begin
        if (selv_reg && sel_reg == {view_bar_reg, 4'(i)})
          step_led[i] <= seq_mem[sel_reg].active ^ (blink_reg < 32'(BLIP_CYC));
        else
          step_led[i] <= seq_mem[{view_bar_reg, 4'(i)}].active;
      end
    end
  end
endmodule : ssc_core

// >>> logic/ssc_sync.sv
// Two-flop synchroniser for a bundle of asynchronous panel and jack levels.
// Assumes each bit is a slow level; multi-bit values may skew by one cycle.
`timescale 1ns/100ps
module ssc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      dout <= '0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : ssc_sync

// >>> sim/ssc_core_properties.sv
// Checker of the core's bus answer, slot display and duplicate flash.
// Assumes only the core's ports; bound into every ssc_core.
`timescale 1ns/100ps
`include "ssc_defs.svh"
module ssc_core_properties #(parameter int DUP_CYC = `SSC_DUP_CYC) (
  // Clock, reset and bus
  input wire logic hclk, hresetn, hsel, hready, hwrite, hreadyout, hresp,
  input wire logic [1:0] htrans,
  input wire logic [31:0] hrdata,
  // Display
  input wire logic [6:0] slot_num,
  input wire logic slot_dp, duplicate_indicator
);
  // Counter, since a repetition cannot reach the full flash length
  int dup_cnt;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) dup_cnt <= 0;
    else dup_cnt <= duplicate_indicator ? dup_cnt + 1 : 0;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
  a_ready_high: assert property (hreadyout == 1'b1) else $error("wait state");
  a_rdata_idle: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_slot_range: assert property (slot_num <= 7'h63) else $error("slot too high");
  a_slot_click: assert property ($past(slot_num) != 7'h00 && slot_num != 7'h00 |->
    slot_num == $past(slot_num) || slot_num == $past(slot_num) + 7'h01 || slot_num == $past(slot_num) - 7'h01)
    else $error("slot jumped");
  a_dp_unarmed: assert property (slot_num == 7'h00 |-> !slot_dp) else $error("stray point");
  a_dup_hold: assert property ($rose(duplicate_indicator) |=> duplicate_indicator [*8])
    else $error("flash too short");
  a_dup_len: assert property (duplicate_indicator |-> dup_cnt < DUP_CYC) else $error("flash too long");
endmodule : ssc_core_properties
bind ssc_core ssc_core_properties #(.DUP_CYC(DUP_CYC)) u_ssc_core_properties (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .hready(hready), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .htrans(htrans),
  .hrdata(hrdata), .slot_num(slot_num), .slot_dp(slot_dp), .duplicate_indicator(duplicate_indicator));

// >>> sim/ssc_core_tb.sv
// Bench of the core: panel model, AHB-Lite master, step and gate model.
// Assumes shortened blink and flash counts set at the instance.
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module ssc_core_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hsel = 1'b1, hreadyout, hresp, gate_out, slot_dp, dup;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [3:0] kmv = 4'h0;
  logic [7:0] kvl = 8'h00;
  logic [13:0] aux;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [15:0] step_led, expv = 16'h0, m;
  logic [6:0] slot_num, s0;
  logic [24:0] pins;
  int mismatches = 0, comparisons = 0, seed = 54, sel = -1, c, i, l;
  always #5 hclk = ~hclk;
  ssc_panel u_ssc_panel (.hclk(hclk), .pins(pins));
  ssc_core #(.BLINK_CYC(40), .BLIP_CYC(6), .DBL_CYC(20), .DUP_CYC(20)) u_ssc_core (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .run_btn(pins[0]), .shift_btn(pins[1]), .store_btn(pins[2]), .recall_btn(pins[3]), .capture_btn(pins[4]),
    .step_btn(pins[24:9]), .enc_up(pins[5]), .enc_dn(pins[6]), .knob_move(kmv), .knob_val(kvl),
    .ext_clk(pins[7]), .ext_rst(pins[8]), .gate_out(gate_out), .pitch_mv(), .aux_voltage_output(aux),
    .step_led(step_led), .slot_num(slot_num), .slot_dp(slot_dp), .duplicate_indicator(dup));
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic bus(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge hclk);
    hwrite <= w;
    haddr <= a;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    q = hrdata;
    if (n >= 50) begin
      mismatches++;
      end_sim();
    end
  endtask : bus
  // One full loop of 16 steps at a tempo of 200 cycles
  task automatic rises(output int n);
    logic p;
    n = 0;
    p = gate_out;
    repeat (3200) begin
      @(posedge hclk);
      n += (gate_out === 1'b1 && p === 1'b0);
      p = gate_out;
    end
  endtask : rises
  task automatic step(input int k);
    if (sel == k) expv[k] = 1'b0;
    else begin
      sel = k;
      expv[k] = 1'b1;
    end
    u_ssc_panel.tap(9 + k);
  endtask : step
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (100) @(posedge hclk);
    bus(1'b0, 32'h4, 32'h0);
    `CHK(q, 32'h00B71B00)
    bus(1'b0, 32'h40, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, 32'h4, 32'hC8);
    repeat (6) step({$random(seed)} % 16);
    m = 16'h1 << sel;
    `CHK(step_led & ~m, expv & ~m)
    l = 0;
    repeat (40) begin
      @(posedge hclk);
      l += step_led[sel];
    end
    `CHK(l > 20, expv[sel])
    kvl <= 8'({$random(seed)} % 101);
    repeat (6) @(posedge hclk);
    kmv <= 4'h8;
    repeat (6) @(posedge hclk);
    kmv <= 4'h0;
    u_ssc_panel.tap(0);
    rises(c);
    `CHK(c, $countones(expv))
    `CHK(aux, (expv >> sel == 1) ? 14'(kvl * 80) : 14'h0)
    u_ssc_panel.tap(7);
    repeat (20) @(posedge hclk);
    rises(c);
    `CHK(c, 0)
    u_ssc_panel.tap(0);
    rises(c);
    `CHK(c, $countones(expv))
    for (i = 2; i < 4; i++) begin
      u_ssc_panel.tap(i);
      s0 = slot_num;
      `CHK(s0 > 7'h00, 1'b1)
      repeat (3) u_ssc_panel.tap(5);
      `CHK(slot_num, (s0 > 7'h60) ? 7'h63 : s0 + 7'h03)
      `CHK(slot_dp, 1'b0)
      u_ssc_panel.tap(1);
      `CHK(slot_num, 7'h00)
    end
    u_ssc_panel.hold(1, 1'b1);
    u_ssc_panel.hold(9, 1'b1);
    u_ssc_panel.tap(11);
    `CHK(dup, 1'b1)
    u_ssc_panel.hold(9, 1'b0);
    u_ssc_panel.tap(11);
    u_ssc_panel.hold(1, 1'b0);
    repeat (30) @(posedge hclk);
    `CHK(step_led & ~m, expv & ~m)
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    end_sim();
  end
endmodule : ssc_core_tb

// >>> sim/ssc_panel.sv
// Front panel and jack model: taps and holds buttons, pulses jacks.
// Assumes hclk from the bench; bit 0 run, 1 shift, 2 store, 3 recall,
// 4 capture, 5 enc up, 6 enc down, 7 ext clock, 8 ext reset, 9-24 steps.
`timescale 1ns/100ps
module ssc_panel (
  // Clock
  input wire logic hclk,
  // Pins
  output logic [24:0] pins
);
  initial pins = 25'h0;
  // Six cycles each way, well past synchroniser and edge detect
  task automatic tap(input int b);
    repeat (6) @(posedge hclk);
    pins[b] <= 1'b1;
    repeat (6) @(posedge hclk);
    pins[b] <= 1'b0;
  endtask : tap
  task automatic hold(input int b, input logic v);
    repeat (6) @(posedge hclk);
    pins[b] <= v;
  endtask : hold
endmodule : ssc_panel
